//--- hw/flash_spi_front.sv
/*
  pin-level serial front end of a serial flash, sampled by SYS_CLK.
  assumes SCK runs well below SYS_CLK/4 and an array engine sits on ARR_*.
*/
// What this block does
// - chip select high: standby once not busy, outputs released
// - deselected: serial input ignored
// - cs falling starts, cs rising ends operation
// - self-timed op continues past cs rising
// - capture input bits on rising clock
// - drive output bits on falling clock
// - dual read drives two bits per fall
// - dual program captures two bits per rise
// - only clock modes 0 and 3
// - write-protect low freezes sector unprotection
// - program writes 1 to 256 bytes, one page
// - erase 4k, 32k, 64k blocks or chip
// - 64 sectors, individual and global protection
// - locked sectors reject program, erase until the next SRST
// - 128-byte security register, each bit programmable once until the next SRST
// - report failures; suspend and resume operations
// - software reset command accepted
module flash_spi_front (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic SRST,
  // serial pins
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic SI_IN,
  output logic DUAL_LANE_UPPER_OUTPUT,
  output logic DUAL_LANE_UPPER_OE,
  input wire logic DUAL_LANE_LOWER_INPUT,
  output logic SO_OUT,
  output logic SO_OE,
  input wire logic WP_N,
  // array engine
  output flash_pkg::arr_req_s ARR_REQ,
  input wire logic [7:0] ARR_RDATA,
  input wire logic ARR_DONE,
  input wire logic ARR_FAIL,
  // state
  output logic STANDBY
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_CMD = 6'h02,
    ST_ADDR = 6'h04,
    ST_DIN = 6'h08,
    ST_DOUT = 6'h10,
    ST_SKIP = 6'h20
  } state_e;

  // ------------------------------------------------------------
  // pins and edges
  // ------------------------------------------------------------
  logic cs_s, sck_s, si_s, soi_s, wp_s;
  logic sck_prev_q, cs_prev_q;
  logic sck_rise, sck_fall, cs_fall;
  logic [63:0] prot;
  flash_pkg::guard_cmd_s gcmd_q, gcmd_d;

  pin_sync #(.W(5), .RST_VAL(flash_pkg::PINS_RESET)) u_sync (
    .clk(SYS_CLK),
    .srst(SRST),
    .d({CS_N, SCK, SI_IN, DUAL_LANE_LOWER_INPUT, WP_N}),
    .q({cs_s, sck_s, si_s, soi_s, wp_s})
  );

  sector_guard #(.N(flash_pkg::SECTORS)) u_guard (
    .clk(SYS_CLK),
    .srst(SRST),
    .cmd(gcmd_q),
    .wp_n(wp_s),
    .prot(prot)
  );

  // sck level at cs fall is never looked at, so idle low or high both work
  assign sck_rise = sck_s & ~sck_prev_q;
  assign sck_fall = ~sck_s & sck_prev_q;
  assign cs_fall = ~cs_s & cs_prev_q;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic sector_ok(input logic [63:0] p, input logic [21:0] a);
    sector_ok = ~p[a[21:flash_pkg::SECTOR_LSB]];
  endfunction

  function automatic logic busy_ok(input logic [7:0] op, input logic susp);
    logic rd;
    rd = (op == flash_pkg::OP_READ) || (op == flash_pkg::OP_DREAD) || (op == flash_pkg::OP_OTP_READ);
    busy_ok = (op == flash_pkg::OP_STATUS) || (op == flash_pkg::OP_SUSPEND) ||
              (op == flash_pkg::OP_RESUME) || (op == flash_pkg::OP_RESET) || (rd && susp);
  endfunction

  // ------------------------------------------------------------
  // protocol state
  // ------------------------------------------------------------
  state_e state_q, state_d;
  logic [7:0] cmd_q, cmd_d;
  logic [21:0] addr_q, addr_d;
  logic [7:0] sr_in_q, sr_in_d;
  logic [7:0] sr_out_q, sr_out_d;
  logic [7:0] rdata_q, rdata_d;
  logic [2:0] cnt_q, cnt_d;
  logic [1:0] abytes_q, abytes_d;
  logic armed_q, armed_d;
  logic wrote_q, wrote_d;
  logic busy_q, busy_d;
  logic susp_q, susp_d;
  logic fail_q, fail_d;
  logic so_q, so_d, so_oe_q, so_oe_d;
  logic sio_q, sio_d, sio_oe_q, sio_oe_d;
  logic standby_q, standby_d;
  flash_pkg::arr_req_s req_q, req_d;
  logic [7:0] otp_q [flash_pkg::OTP_BYTES];
  logic [7:0] otp_d [flash_pkg::OTP_BYTES];

  logic dual;
  logic [2:0] step, cnt_nx;
  logic [7:0] in_next, out_byte, status, out_b;
  logic byte_done;
  logic [21:0] full_addr;

  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    addr_d = addr_q;
    sr_in_d = sr_in_q;
    sr_out_d = sr_out_q;
    rdata_d = rdata_q;
    cnt_d = cnt_q;
    abytes_d = abytes_q;
    armed_d = armed_q;
    wrote_d = wrote_q;
    busy_d = busy_q;
    susp_d = susp_q;
    fail_d = fail_q;
    so_d = so_q;
    so_oe_d = so_oe_q;
    sio_d = sio_q;
    sio_oe_d = sio_oe_q;
    otp_d = otp_q;
    gcmd_d = '0;
    req_d = req_q;
    req_d.rd = 1'b0;
    req_d.wr = 1'b0;
    req_d.start = 1'b0;
    req_d.abort = 1'b0;

    dual = ((state_q == ST_DIN) || (state_q == ST_DOUT)) &&
           ((cmd_q == flash_pkg::OP_DREAD) || (cmd_q == flash_pkg::OP_DPROG));
    step = dual ? 3'h2 : 3'h1;
    cnt_nx = cnt_q + step;
    byte_done = (cnt_nx == 3'h0);
    in_next = dual ? {sr_in_q[5:0], soi_s, si_s} : {sr_in_q[6:0], si_s};
    full_addr = {addr_q[13:0], in_next};
    status = {busy_q, fail_q, susp_q, wp_s, |prot, 3'h0};
    if (cmd_q == flash_pkg::OP_STATUS) out_byte = status;
    else if (cmd_q == flash_pkg::OP_OTP_READ) out_byte = otp_q[addr_q[6:0]];
    else out_byte = rdata_q;
    out_b = (cnt_q == 3'h0) ? out_byte : sr_out_q;

    if (req_q.rd) rdata_d = ARR_RDATA;
    if (ARR_DONE) begin
      busy_d = 1'b0;
      susp_d = 1'b0;
      fail_d = fail_q | ARR_FAIL;
    end

    if (cs_s) begin
      // ------------------------------------------------------------
      // deselected: release lines, run what the frame asked for
      // ------------------------------------------------------------
      so_oe_d = 1'b0;
      sio_oe_d = 1'b0;
      state_d = ST_IDLE;
      if ((state_q != ST_IDLE) && armed_q) begin
        if (!busy_q && ((cmd_q == flash_pkg::OP_PROG) || (cmd_q == flash_pkg::OP_DPROG)) && wrote_q) begin
          if (sector_ok(prot, addr_q)) begin
            req_d.start = 1'b1;
            req_d.op = flash_pkg::AOP_PROG;
            busy_d = 1'b1;
            fail_d = 1'b0;
          end else begin
            fail_d = 1'b1;
          end
        end
        if (!busy_q && ((cmd_q == flash_pkg::OP_ER4K) || (cmd_q == flash_pkg::OP_ER32K) ||
                        (cmd_q == flash_pkg::OP_ER64K))) begin
          if (sector_ok(prot, addr_q)) begin
            req_d.start = 1'b1;
            busy_d = 1'b1;
            fail_d = 1'b0;
            if (cmd_q == flash_pkg::OP_ER4K) begin
              req_d.op = flash_pkg::AOP_ER4K;
              req_d.addr = addr_q & ~flash_pkg::MASK_4K;
            end else if (cmd_q == flash_pkg::OP_ER32K) begin
              req_d.op = flash_pkg::AOP_ER32K;
              req_d.addr = addr_q & ~flash_pkg::MASK_32K;
            end else begin
              req_d.op = flash_pkg::AOP_ER64K;
              req_d.addr = addr_q & ~flash_pkg::MASK_64K;
            end
          end else begin
            fail_d = 1'b1;
          end
        end
        if (!busy_q && (cmd_q == flash_pkg::OP_ERCHIP)) begin
          // one protected sector blocks the whole-array erase
          if (~|prot) begin
            req_d.start = 1'b1;
            req_d.op = flash_pkg::AOP_ERCHIP;
            req_d.addr = '0;
            busy_d = 1'b1;
            fail_d = 1'b0;
          end else begin
            fail_d = 1'b1;
          end
        end
        gcmd_d.sector = addr_q[21:flash_pkg::SECTOR_LSB];
        gcmd_d.prot = !busy_q && (cmd_q == flash_pkg::OP_PROT);
        gcmd_d.unprot = !busy_q && (cmd_q == flash_pkg::OP_UNPROT);
        gcmd_d.gprot = !busy_q && (cmd_q == flash_pkg::OP_GPROT);
        gcmd_d.gunprot = !busy_q && (cmd_q == flash_pkg::OP_GUNPROT);
        gcmd_d.lock = !busy_q && (cmd_q == flash_pkg::OP_LOCK);
        if ((cmd_q == flash_pkg::OP_SUSPEND) && busy_q && !ARR_DONE) susp_d = 1'b1;
        if (cmd_q == flash_pkg::OP_RESUME) susp_d = 1'b0;
        if (cmd_q == flash_pkg::OP_RESET) begin
          req_d.abort = busy_q;
          busy_d = 1'b0;
          susp_d = 1'b0;
          // a failure reported in this very cycle is not lost
          fail_d = ARR_DONE & ARR_FAIL;
        end
      end
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (cs_fall) begin
            state_d = ST_CMD;
            cnt_d = 3'h0;
            abytes_d = 2'h0;
            armed_d = 1'b0;
            wrote_d = 1'b0;
          end
        end
        ST_CMD: begin
          if (sck_rise) begin
            sr_in_d = in_next;
            cnt_d = cnt_nx;
            if (byte_done) begin
              cmd_d = in_next;
              if (busy_q && !busy_ok(in_next, susp_q)) begin
                state_d = ST_SKIP;
              end else if (in_next == flash_pkg::OP_STATUS) begin
                state_d = ST_DOUT;
              end else if ((in_next == flash_pkg::OP_ERCHIP) || (in_next == flash_pkg::OP_GPROT) ||
                           (in_next == flash_pkg::OP_GUNPROT) || (in_next == flash_pkg::OP_SUSPEND) ||
                           (in_next == flash_pkg::OP_RESUME) || (in_next == flash_pkg::OP_RESET)) begin
                state_d = ST_SKIP;
                armed_d = 1'b1;
              end else begin
                state_d = ST_ADDR;
              end
            end
          end
        end
        ST_ADDR: begin
          if (sck_rise) begin
            sr_in_d = in_next;
            cnt_d = cnt_nx;
            if (byte_done) begin
              addr_d = full_addr;
              abytes_d = abytes_q + 2'h1;
              if (abytes_q == 2'h2) begin
                armed_d = 1'b1;
                if ((cmd_q == flash_pkg::OP_READ) || (cmd_q == flash_pkg::OP_DREAD) ||
                    (cmd_q == flash_pkg::OP_OTP_READ)) begin
                  state_d = ST_DOUT;
                  req_d.rd = 1'b1;
                  req_d.addr = full_addr;
                end else if ((cmd_q == flash_pkg::OP_PROG) || (cmd_q == flash_pkg::OP_DPROG) ||
                             (cmd_q == flash_pkg::OP_OTP_PROG)) begin
                  state_d = ST_DIN;
                end else begin
                  state_d = ST_SKIP;
                end
              end
            end
          end
        end
        ST_DIN: begin
          if (sck_rise) begin
            sr_in_d = in_next;
            cnt_d = cnt_nx;
            if (byte_done) begin
              // address wraps inside the page, so one frame never leaves it
              addr_d = {addr_q[21:flash_pkg::PAGE_W], addr_q[7:0] + 8'h1};
              if (cmd_q == flash_pkg::OP_OTP_PROG) begin
                // bits only clear, so each bit can be programmed once until SRST reloads OTP_RESET
                otp_d[addr_q[6:0]] = otp_q[addr_q[6:0]] & in_next;
              end else begin
                wrote_d = 1'b1;
                req_d.wr = sector_ok(prot, addr_q);
                req_d.addr = addr_q;
                req_d.wdata = in_next;
              end
            end
          end
        end
        ST_DOUT: begin
          if (sck_fall) begin
            so_d = out_b[7];
            so_oe_d = 1'b1;
            if (dual) begin
              sio_d = out_b[6];
              sio_oe_d = 1'b1;
            end
            sr_out_d = dual ? {out_b[5:0], 2'h0} : {out_b[6:0], 1'h0};
            cnt_d = cnt_nx;
            if ((cnt_q == 3'h0) && (cmd_q != flash_pkg::OP_STATUS)) begin
              // fetch the following byte while this one shifts out
              addr_d = addr_q + 22'h1;
              req_d.rd = (cmd_q != flash_pkg::OP_OTP_READ);
              req_d.addr = addr_q + 22'h1;
            end
          end
        end
        default: begin
        end
      endcase
    end
    req_d.suspend = susp_d;
    standby_d = cs_s & ~busy_d;
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      state_q <= ST_IDLE;
      cmd_q <= 8'h00;
      addr_q <= '0;
      sr_in_q <= 8'h00;
      sr_out_q <= 8'h00;
      rdata_q <= 8'h00;
      cnt_q <= 3'h0;
      abytes_q <= 2'h0;
      armed_q <= 1'b0;
      wrote_q <= 1'b0;
      busy_q <= 1'b0;
      susp_q <= 1'b0;
      fail_q <= 1'b0;
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
      sio_q <= 1'b0;
      sio_oe_q <= 1'b0;
      standby_q <= 1'b1;
      req_q <= '0;
      gcmd_q <= '0;
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
      for (int i = 0; i < flash_pkg::OTP_BYTES; i++) otp_q[i] <= flash_pkg::OTP_RESET;
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      addr_q <= addr_d;
      sr_in_q <= sr_in_d;
      sr_out_q <= sr_out_d;
      rdata_q <= rdata_d;
      cnt_q <= cnt_d;
      abytes_q <= abytes_d;
      armed_q <= armed_d;
      wrote_q <= wrote_d;
      busy_q <= busy_d;
      susp_q <= susp_d;
      fail_q <= fail_d;
      so_q <= so_d;
      so_oe_q <= so_oe_d;
      sio_q <= sio_d;
      sio_oe_q <= sio_oe_d;
      standby_q <= standby_d;
      req_q <= req_d;
      gcmd_q <= gcmd_d;
      sck_prev_q <= sck_s;
      cs_prev_q <= cs_s;
      otp_q <= otp_d;
    end
  end

  assign SO_OUT = so_q;
  assign SO_OE = so_oe_q;
  assign DUAL_LANE_UPPER_OUTPUT = sio_q;
  assign DUAL_LANE_UPPER_OE = sio_oe_q;
  assign ARR_REQ = req_q;
  assign STANDBY = standby_q;
endmodule

//--- shared/flash_pkg.sv
/*
  constants and carriers shared by the serial flash pin interface.
  assumes a 22-bit byte address space behind the pins (4 Mbyte array).
*/
package flash_pkg;
  // ------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------
  localparam int ADDR_W = 22;
  localparam int SECTORS = 64;
  localparam int SECTOR_LSB = 16;
  localparam int OTP_BYTES = 128;
  localparam int PAGE_W = 8;
  localparam logic [21:0] MASK_4K = 22'h000fff;
  localparam logic [21:0] MASK_32K = 22'h007fff;
  localparam logic [21:0] MASK_64K = 22'h00ffff;

  // ------------------------------------------------------------
  // opcodes
  // ------------------------------------------------------------
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_DREAD = 8'h3b;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_DPROG = 8'ha2;
  localparam logic [7:0] OP_ER4K = 8'h20;
  localparam logic [7:0] OP_ER32K = 8'h52;
  localparam logic [7:0] OP_ER64K = 8'hd8;
  localparam logic [7:0] OP_ERCHIP = 8'h60;
  localparam logic [7:0] OP_PROT = 8'h36;
  localparam logic [7:0] OP_UNPROT = 8'h39;
  localparam logic [7:0] OP_GPROT = 8'h7e;
  localparam logic [7:0] OP_GUNPROT = 8'h7f;
  localparam logic [7:0] OP_LOCK = 8'h33;
  localparam logic [7:0] OP_OTP_PROG = 8'h9b;
  localparam logic [7:0] OP_OTP_READ = 8'h77;
  localparam logic [7:0] OP_STATUS = 8'h05;
  localparam logic [7:0] OP_SUSPEND = 8'hb0;
  localparam logic [7:0] OP_RESUME = 8'hd0;
  localparam logic [7:0] OP_RESET = 8'hf0;

  // ------------------------------------------------------------
  // array operations and reset values
  // ------------------------------------------------------------
  localparam logic [2:0] AOP_PROG = 3'h0;
  localparam logic [2:0] AOP_ER4K = 3'h1;
  localparam logic [2:0] AOP_ER32K = 3'h2;
  localparam logic [2:0] AOP_ER64K = 3'h3;
  localparam logic [2:0] AOP_ERCHIP = 3'h4;
  localparam logic [7:0] OTP_RESET = 8'hff;
  localparam logic [63:0] PROT_RESET = 64'hffffffffffffffff;
  localparam logic [63:0] LOCK_RESET = 64'h0;
  // order {cs_n, sck, si, soi, wp_n}; cs_n and wp_n rest high
  localparam logic [4:0] PINS_RESET = 5'h11;

  typedef struct packed {
    logic rd;
    logic wr;
    logic start;
    logic abort;
    logic suspend;
    logic [2:0] op;
    logic [21:0] addr;
    logic [7:0] wdata;
  } arr_req_s;

  typedef struct packed {
    logic prot;
    logic unprot;
    logic gprot;
    logic gunprot;
    logic lock;
    logic [5:0] sector;
  } guard_cmd_s;
endpackage

//--- hw/pin_sync.sv
/*
  two-flop synchroniser for a bundle of pin levels.
  assumes each bit is an independent level from outside SYS_CLK.
*/
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  always_comb begin
    meta_d = d;
    q_d = meta_q;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      q <= q_d;
    end
  end
endmodule

//--- hw/sector_guard.sv
/*
  per-sector protection and lockdown bits.
  assumes commands arrive as one-cycle pulses and wp_n is synchronised.
*/
module sector_guard #(
  parameter int N = flash_pkg::SECTORS
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // commands
  input wire flash_pkg::guard_cmd_s cmd,
  input wire logic wp_n,
  // state
  output logic [N-1:0] prot
);
  logic [N-1:0] prot_q;
  logic [N-1:0] prot_d;
  logic [N-1:0] lock_q;
  logic [N-1:0] lock_d;

  always_comb begin
    prot_d = prot_q;
    lock_d = lock_q;
    if (cmd.prot) prot_d[cmd.sector] = 1'b1;
    if (cmd.gprot) prot_d = '1;
    // wp low freezes every protected sector as it is
    if (wp_n && cmd.unprot) prot_d[cmd.sector] = 1'b0;
    if (wp_n && cmd.gunprot) prot_d = '0;
    if (cmd.lock) lock_d[cmd.sector] = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      prot_q <= flash_pkg::PROT_RESET;
      lock_q <= flash_pkg::LOCK_RESET;
    end else begin
      prot_q <= prot_d;
      lock_q <= lock_d;
    end
  end

  // locked sectors stay read-only whatever the protect bits say
  assign prot = prot_q | lock_q;
endmodule

//--- verif/flash_front_monitor.sv
/*
  port assertions for the serial flash front end.
  assumes it is bound onto flash_spi_front; one clock domain, SRST synchronous.
*/
module flash_front_monitor (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic SRST,
  // serial pins
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic SO_OUT,
  input wire logic SO_OE,
  input wire logic DUAL_LANE_UPPER_OE,
  // array side and state
  input wire flash_pkg::arr_req_s ARR_REQ,
  input wire logic ARR_DONE,
  input wire logic STANDBY
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);

  // ------------------------------------------------------------
  // sequences
  // ------------------------------------------------------------
  sequence s_deselected;
    CS_N [*6];
  endsequence
  // pin fell four edges back: two sync flops, edge detect, output flop
  sequence s_sck_fell;
    $past(SCK, 4) && !$past(SCK, 3);
  endsequence

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_release;
    $rose(CS_N) |-> ##[1:6] (!SO_OE && !DUAL_LANE_UPPER_OE);
  endproperty
  property p_idle_hiz;
    s_deselected |-> !SO_OE && !DUAL_LANE_UPPER_OE;
  endproperty
  property p_idle_quiet;
    s_deselected |-> !ARR_REQ.wr && !ARR_REQ.rd;
  endproperty
  property p_busy;
    ARR_REQ.start |=> !STANDBY;
  endproperty
  property p_so_fall;
    $changed(SO_OUT) && SO_OE && $past(SO_OE) |-> s_sck_fell;
  endproperty
  property p_dual_sel;
    $rose(DUAL_LANE_UPPER_OE) |-> !CS_N;
  endproperty
  property p_start_end;
    ARR_REQ.start |-> CS_N;
  endproperty
  property p_back_idle;
    CS_N && ARR_DONE |-> ##[1:3] STANDBY;
  endproperty

  a_release: assert property (p_release) else $error("serial outputs still driven after deselect");
  a_idle_hiz: assert property (p_idle_hiz) else $error("serial output enabled while deselected");
  a_idle_quiet: assert property (p_idle_quiet) else $error("array access while deselected");
  a_busy: assert property (p_busy) else $error("standby during self-timed operation");
  a_so_fall: assert property (p_so_fall) else $error("output bit changed off a clock fall");
  a_dual_sel: assert property (p_dual_sel) else $error("upper lane driven while deselected");
  a_start_end: assert property (p_start_end) else $error("array operation started inside a frame");
  a_back_idle: assert property (p_back_idle) else $error("no standby after operation finished");
endmodule

//--- verif/flash_array_model.sv
/*
  behavioural array engine behind the front end.
  assumes start, wr, abort are one-cycle pulses; done latency set by DONE_DELAY.
*/
module flash_array_model (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic SRST,
  // array engine side
  input wire flash_pkg::arr_req_s ARR_REQ,
  input wire logic [7:0] DONE_DELAY,
  output logic [7:0] ARR_RDATA,
  output logic ARR_DONE,
  output logic ARR_FAIL
);
  timeunit 1ns;
  timeprecision 1ps;
  int n_wr = 0;
  int n_start = 0;
  logic [21:0] wr_addr;
  logic [7:0] wr_data;
  logic [2:0] st_op;
  logic [21:0] st_addr;
  logic [7:0] cnt_q = 8'h00;

  // read data follows the address so the bench can predict it
  assign ARR_RDATA = ARR_REQ.addr[7:0] ^ 8'h5a;
  assign ARR_FAIL = 1'b0;

  always @(posedge SYS_CLK) begin
    ARR_DONE <= !SRST && (cnt_q == 8'h01);
    if (SRST || ARR_REQ.abort) begin
      cnt_q <= 8'h00;
    end else if (ARR_REQ.start) begin
      cnt_q <= DONE_DELAY;
      n_start <= n_start + 1;
      st_op <= ARR_REQ.op;
      st_addr <= ARR_REQ.addr;
    end else if (cnt_q != 8'h00 && !ARR_REQ.suspend) begin
      cnt_q <= cnt_q - 8'h01;
    end
    if (ARR_REQ.wr) begin
      n_wr <= n_wr + 1;
      wr_addr <= ARR_REQ.addr;
      wr_data <= ARR_REQ.wdata;
    end
  end
endmodule

//--- verif/testbench.sv
/*
  self-checking bench for flash_spi_front acting as an spi host in mode 0.
  assumes flash_array_model on the array side; sck period 80 ns.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic SYS_CLK = 1'b0;
  logic SRST = 1'b1;
  logic CS_N = 1'b1;
  logic SCK = 1'b0;
  logic WP_N = 1'b1;
  logic si_h = 1'b0;
  logic so_h = 1'b0;
  logic [7:0] delay = 8'h04;
  logic SI_IN, DUAL_LANE_UPPER_OUTPUT, DUAL_LANE_UPPER_OE, DUAL_LANE_LOWER_INPUT;
  logic SO_OUT, SO_OE, STANDBY, ARR_DONE, ARR_FAIL;
  logic [7:0] ARR_RDATA;
  flash_pkg::arr_req_s ARR_REQ;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [7:0] er_op [3] = '{flash_pkg::OP_ER4K, flash_pkg::OP_ER32K, flash_pkg::OP_ER64K};
  logic [21:0] er_mask [3] = '{flash_pkg::MASK_4K, flash_pkg::MASK_32K, flash_pkg::MASK_64K};
  logic [2:0] er_aop [3] = '{flash_pkg::AOP_ER4K, flash_pkg::AOP_ER32K, flash_pkg::AOP_ER64K};

  always #5 SYS_CLK = ~SYS_CLK;
  // pin levels resolved from the DUT's enables, host level otherwise
  assign SI_IN = DUAL_LANE_UPPER_OE ? DUAL_LANE_UPPER_OUTPUT : si_h;
  assign DUAL_LANE_LOWER_INPUT = SO_OE ? SO_OUT : so_h;

  flash_spi_front DUT (.SYS_CLK(SYS_CLK), .SRST(SRST), .CS_N(CS_N), .SCK(SCK), .SI_IN(SI_IN),
    .DUAL_LANE_UPPER_OUTPUT(DUAL_LANE_UPPER_OUTPUT), .DUAL_LANE_UPPER_OE(DUAL_LANE_UPPER_OE),
    .DUAL_LANE_LOWER_INPUT(DUAL_LANE_LOWER_INPUT), .SO_OUT(SO_OUT), .SO_OE(SO_OE), .WP_N(WP_N),
    .ARR_REQ(ARR_REQ), .ARR_RDATA(ARR_RDATA), .ARR_DONE(ARR_DONE), .ARR_FAIL(ARR_FAIL), .STANDBY(STANDBY));
  flash_array_model array_model (.SYS_CLK(SYS_CLK), .SRST(SRST), .ARR_REQ(ARR_REQ), .DONE_DELAY(delay),
    .ARR_RDATA(ARR_RDATA), .ARR_DONE(ARR_DONE), .ARR_FAIL(ARR_FAIL));

  // ------------------------------------------------------------
  // host primitives
  // ------------------------------------------------------------
  task automatic finish_test();
    if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask
  // low phase 5 cycles so the output bit has landed before the rise
  task automatic bit_x(input logic si, input logic so, output logic [1:0] rx);
    SCK <= 1'b0; // data set while clock low, mode 0 idle low
    si_h <= si;
    so_h <= so; // second lane only matters in dual program
    tick(5);
    rx = {SO_OUT, DUAL_LANE_UPPER_OUTPUT};
    SCK <= 1'b1;
    tick(3);
  endtask
  task automatic send(input logic [7:0] b);
    logic [1:0] r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], 1'b0, r);
  endtask
  task automatic recv(output logic [7:0] b);
    logic [1:0] r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b0, 1'b0, r);
      b[i] = r[1];
    end
  endtask
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input bit has_a);
    CS_N <= 1'b0; // falling select opens the operation
    tick(2);
    send(op);
    if (has_a) begin
      send(a[23:16]);
      send(a[15:8]);
      send(a[7:0]);
    end
  endtask
  task automatic end_frame();
    SCK <= 1'b0;
    tick(4);
    CS_N <= 1'b1; // rising select closes it
    tick(8);
  endtask
  task automatic wait_standby();
    for (int i = 0; i < 400 && STANDBY !== 1'b1; i++) tick(1);
    cmp("standby", 32'h1, STANDBY);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_idle();
    int w0 = array_model.n_wr;
    cmp("oe_reset", 32'h0, {SO_OE, DUAL_LANE_UPPER_OE});
    send(flash_pkg::OP_PROG);
    send(8'ha5);
    tick(10);
    cmp("wr_deselected", w0, array_model.n_wr);
    cmp("standby", 32'h1, STANDBY);
  endtask
  task automatic t_program();
    int w0;
    frame(flash_pkg::OP_GUNPROT, 24'h0, 1'b0);
    end_frame();
    w0 = array_model.n_wr;
    delay <= 8'h28; // slow engine
    frame(flash_pkg::OP_PROG, 24'h0100ff, 1'b1);
    send(8'ha5);
    send(8'h3c);
    end_frame();
    cmp("standby_busy", 32'h0, STANDBY);
    wait_standby();
    cmp("wr_count", w0 + 2, array_model.n_wr);
    cmp("wr_addr_wrap", 32'h010000, array_model.wr_addr);
    cmp("wr_data", 32'h3c, array_model.wr_data);
    cmp("prog_op", flash_pkg::AOP_PROG, array_model.st_op);
    delay <= 8'h04;
  endtask
  task automatic t_erase();
    for (int i = 0; i < 3; i++) begin
      frame(er_op[i], 24'h123456, 1'b1);
      end_frame();
      wait_standby();
      cmp("erase_op", er_aop[i], array_model.st_op);
      cmp("erase_addr", 22'h123456 & ~er_mask[i], array_model.st_addr);
    end
    frame(flash_pkg::OP_ERCHIP, 24'h0, 1'b0);
    end_frame();
    wait_standby();
    cmp("chip_op", flash_pkg::AOP_ERCHIP, array_model.st_op);
    cmp("chip_addr", 32'h0, array_model.st_addr);
  endtask
  task automatic t_dprog();
    logic [1:0] r;
    frame(flash_pkg::OP_DPROG, 24'h020005, 1'b1);
    for (int k = 0; k < 4; k++) bit_x(1'(8'hc6 >> (6 - 2 * k)), 1'(8'hc6 >> (7 - 2 * k)), r);
    end_frame();
    wait_standby();
    cmp("dual_wdata", 32'hc6, array_model.wr_data);
    cmp("dual_addr", 32'h020005, array_model.wr_addr);
  endtask
  task automatic t_protect();
    int s0;
    logic [7:0] b;
    frame(flash_pkg::OP_GPROT, 24'h0, 1'b0);
    end_frame();
    WP_N <= 1'b0; // write-protect low: global unprotect must be refused
    frame(flash_pkg::OP_GUNPROT, 24'h0, 1'b0);
    end_frame();
    s0 = array_model.n_start;
    frame(flash_pkg::OP_PROG, 24'h010000, 1'b1);
    send(8'h00);
    end_frame();
    tick(20);
    cmp("prot_start", s0, array_model.n_start);
    frame(flash_pkg::OP_STATUS, 24'h0, 1'b0);
    recv(b);
    end_frame();
    cmp("status_fail", 32'h48, b);
  endtask
  task automatic t_read();
    logic [7:0] b;
    frame(flash_pkg::OP_READ, 24'h000010, 1'b1);
    recv(b);
    cmp("read0", 32'h4a, b);
    recv(b);
    cmp("read1", 32'h4b, b);
    cmp("so_oe_on", 32'h1, SO_OE);
    end_frame();
    cmp("so_oe_off", 32'h0, SO_OE);
  endtask
  task automatic t_dread();
    logic [1:0] r;
    logic [7:0] b;
    frame(flash_pkg::OP_DREAD, 24'h000020, 1'b1);
    for (int k = 0; k < 4; k++) begin
      bit_x(1'b0, 1'b0, r);
      b[7 - 2 * k] = r[1];
      b[6 - 2 * k] = r[0];
    end
    cmp("dual_read", 32'h7a, b);
    cmp("upper_oe_on", 32'h1, DUAL_LANE_UPPER_OE);
    end_frame();
    cmp("upper_oe_off", 32'h0, DUAL_LANE_UPPER_OE);
  endtask

  // ------------------------------------------------------------
  // run and watchdog
  // ------------------------------------------------------------
  always @(posedge SYS_CLK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    tick(2);
    SRST <= 1'b0;
    tick(4);
    t_idle();
    t_program();
    t_erase();
    t_dprog();
    t_protect();
    t_read();
    t_dread();
    finish_test();
  end
endmodule

bind flash_spi_front flash_front_monitor u_mon (.SYS_CLK(SYS_CLK), .SRST(SRST), .CS_N(CS_N), .SCK(SCK),
  .SO_OUT(SO_OUT), .SO_OE(SO_OE), .DUAL_LANE_UPPER_OE(DUAL_LANE_UPPER_OE), .ARR_REQ(ARR_REQ),
  .ARR_DONE(ARR_DONE), .STANDBY(STANDBY));
